// ### hw/spi_port_regs.svh
// Constant names for the serial port: mode codes, divider counts and frame sizes
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

`define MODE_MASTER_DIV4 3'h0
`define MODE_MASTER_DIV16 3'h1
`define MODE_MASTER_DIV64 3'h2
`define MODE_MASTER_SUB 3'h3
`define MODE_MASTER_TIMER 3'h4
`define MODE_SLAVE 3'h5
`define MODE_TWO_WIRE 3'h6
`define MODE_OFF 3'h7

`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20

`define FRAME_BITS 4'h8
`define FRAME_LAST_EDGE 5'h0f
`define FRAME_LAST_SAMPLE 4'h7

`define PIN_SDI 2'h0
`define PIN_SCK 2'h1
`define PIN_SEL 2'h2
`define PIN_SUB 2'h3

`endif

// ### hw/spi_port_pkg.sv
// Types shared by the serial port files
package spi_port_pkg;

  typedef struct packed {
    logic [2:0] mode;
    logic enable;
    logic idle_low;
    logic edge_sel;
    logic msb_first;
    logic sel_en;
  } spi_cfg_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_WAIT_SEL,
    S_SHIFT
  } spi_state_t;

endpackage

// ### hw/two_entry_buffer.sv
// Small register FIFO with valid/ready on both sides and registered flags
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      count <= next_count;
      // Flags come from the next count so both sides see honest state
      in_ready_o <= (next_count != CW'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end

endmodule

`default_nettype wire

// ### hw/spi_port.sv
// Four-line serial port of the serial module, master or slave, eight-bit frames
//
// Contract
// - Each serial clock shifts one bit out and one bit in together.
// - Link lines are data in, data out, serial clock and low-active select.
// - Only the master starts a transfer; a slave waits for it.
// - Master drives the serial clock; slave only follows the incoming clock.
// - One select pin, so a master addresses exactly one slave.
// - Select enable high makes the select pin the port's select line.
// - Select enable low releases the select pin to other functions.
// - Module enable switches the whole configured port on or off.
// - Mode field chooses four-line serial or the two-wire mode.
// - Port works both as master and as slave.
// - Frames go least or most significant bit first, as configured.
// - Software picks rising or falling serial clock edge for sampling.
// - Pin directions follow master/slave mode, select enable and module enable.
// - Pins join the port only once pin-sharing assigns them to it.
// - Input pull-ups on only when selected and the module is enabled.
// - Codes 0-4 master clock sources, 5 slave, 6 two-wire, 7 off.
// - Polarity bit zero idles the clock high, one idles it low.
// - Bit order one is most significant first, zero least first.
// - Slave deselected mid-frame sets incomplete together with done.
`timescale 1ns/100ps
`default_nettype none
`include "spi_port_regs.svh"

module spi_port
  import spi_port_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] module_mode_field_i,
  input wire logic module_enable_i,
  input wire logic pin_function_select_i,
  input wire logic [2:0] pullup_select_i,
  input wire logic clock_idle_polarity_i,
  input wire logic clock_edge_select_i,
  input wire logic bit_order_select_i,
  input wire logic select_pin_enable_i,
  input wire logic sub_clock_i,
  input wire logic timer_match_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  output logic transfer_done_flag_o,
  input wire logic transfer_done_clear_i,
  output logic incomplete_transfer_flag_o,
  input wire logic incomplete_clear_i,
  input wire logic incomplete_set_i,
  output logic busy_o,
  output logic two_wire_mode_o,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic slave_select_n_i,
  output logic slave_select_n_o,
  output logic slave_select_n_oe_o,
  output logic [2:0] pullup_en_o
);

  // ***************************************************************
  // Configuration decode
  // ***************************************************************
  spi_cfg_t cfg;
  logic is_master;
  logic is_slave;
  logic port_on;
  logic sample_rising;
  logic idle_level;

  assign cfg = '{mode: module_mode_field_i, enable: module_enable_i, idle_low: clock_idle_polarity_i,
                 edge_sel: clock_edge_select_i, msb_first: bit_order_select_i,
                 sel_en: select_pin_enable_i};

  function automatic logic mode_is_master(input logic [2:0] m);
    mode_is_master = (m <= `MODE_MASTER_TIMER);
  endfunction

  assign is_master = mode_is_master(cfg.mode);
  assign is_slave = (cfg.mode == `MODE_SLAVE);
  assign port_on = cfg.enable && pin_function_select_i && (is_master || is_slave);
  assign idle_level = ~cfg.idle_low;
  assign sample_rising = ~(cfg.idle_low ^ cfg.edge_sel);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
      pin_s3 <= 4'hf;
    end else begin
      pin_s1 <= {sub_clock_i, slave_select_n_i, sck_i, sdi_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  logic slave_edge;
  logic slave_rise;
  logic selected;

  assign slave_edge = pin_s2[`PIN_SCK] ^ pin_s3[`PIN_SCK];
  assign slave_rise = pin_s2[`PIN_SCK] & ~pin_s3[`PIN_SCK];
  // Without select enable a slave treats itself as always selected
  assign selected = !cfg.sel_en || !pin_s2[`PIN_SEL];

  // ***************************************************************
  // Master clock source
  // ***************************************************************
  logic [5:0] div_cnt;
  logic [5:0] half_period;
  logic master_tick;
  spi_state_t state;

  always_comb begin
    half_period = `HALF_DIV64;
    if (cfg.mode == `MODE_MASTER_DIV4) begin
      half_period = `HALF_DIV4;
    end else if (cfg.mode == `MODE_MASTER_DIV16) begin
      half_period = `HALF_DIV16;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || state != S_SHIFT || !is_master) begin
      div_cnt <= 6'h00;
    end else if (div_cnt == 6'(half_period - 6'h01)) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= 6'(div_cnt + 6'h01);
    end
  end

  always_comb begin
    if (cfg.mode == `MODE_MASTER_SUB) begin
      master_tick = pin_s2[`PIN_SUB] ^ pin_s3[`PIN_SUB];
    end else if (cfg.mode == `MODE_MASTER_TIMER) begin
      // One toggle per match gives half the match frequency
      master_tick = timer_match_i;
    end else begin
      master_tick = (div_cnt == 6'(half_period - 6'h01));
    end
  end

  // ***************************************************************
  // Shift engine
  // ***************************************************************
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic [4:0] edge_cnt;
  logic [3:0] sample_cnt;
  logic line_edge;
  logic edge_rise;
  logic is_sample;
  logic push_valid;
  logic [7:0] push_data;
  logic buf_ready;
  logic tx_take;
  logic [1:0] cap_pipe;

  function automatic logic out_bit(input logic [7:0] d, input logic msb);
    out_bit = msb ? d[7] : d[0];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic msb);
    shift_in = msb ? {d[6:0], b} : {b, d[7:1]};
  endfunction

  assign line_edge = (state == S_SHIFT) && (is_master ? master_tick : slave_edge);
  assign edge_rise = is_master ? !sck_o : slave_rise;
  assign is_sample = (edge_rise == sample_rising);
  assign tx_take = tx_valid_i && tx_ready_o;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      edge_cnt <= 5'h00;
      sample_cnt <= 4'h0;
      push_valid <= 1'b0;
      push_data <= 8'h00;
      sdo_o <= 1'b0;
      sck_o <= 1'b1;
      cap_pipe <= 2'b00;
    end else begin
      push_valid <= 1'b0;
      cap_pipe <= {cap_pipe[0], 1'b0};
      // Master reads data two cycles after its own sample edge, once the synchroniser has caught up
      if (cap_pipe[1] && port_on) begin
        rx_shift <= shift_in(rx_shift, pin_s2[`PIN_SDI], cfg.msb_first);
        if (sample_cnt == `FRAME_BITS) begin
          push_valid <= 1'b1;
          push_data <= shift_in(rx_shift, pin_s2[`PIN_SDI], cfg.msb_first);
        end
      end
      if (!port_on) begin
        cap_pipe <= 2'b00;
        state <= S_IDLE;
        sck_o <= idle_level;
      end else begin
        case (state)
          S_IDLE: begin
            sck_o <= idle_level;
            if (tx_take) begin
              tx_shift <= tx_data_i;
              sdo_o <= out_bit(tx_data_i, cfg.msb_first);
              edge_cnt <= 5'h00;
              sample_cnt <= 4'h0;
              // Master launches at once; a slave waits for its master
              state <= is_master ? S_SHIFT : S_WAIT_SEL;
            end
          end
          S_WAIT_SEL: begin
            if (selected) begin
              state <= S_SHIFT;
            end
          end
          S_SHIFT: begin
            if (is_slave && !selected) begin
              state <= S_IDLE;
            end else if (line_edge) begin
              if (is_master) begin
                sck_o <= ~sck_o;
                edge_cnt <= 5'(edge_cnt + 5'h01);
              end
              if (is_sample) begin
                if (is_master) begin
                  cap_pipe[0] <= 1'b1;
                end else begin
                  rx_shift <= shift_in(rx_shift, pin_s2[`PIN_SDI], cfg.msb_first);
                end
                sample_cnt <= 4'(sample_cnt + 4'h1);
              end else if (sample_cnt != 4'h0) begin
                tx_shift <= shift_in(tx_shift, 1'b0, cfg.msb_first);
                sdo_o <= out_bit(shift_in(tx_shift, 1'b0, cfg.msb_first), cfg.msb_first);
              end
              // Master ends after sixteen toggles so the clock is back at idle
              if (is_master && edge_cnt == `FRAME_LAST_EDGE) begin
                state <= S_IDLE;
              end else if (is_slave && is_sample && sample_cnt == `FRAME_LAST_SAMPLE) begin
                push_valid <= 1'b1;
                push_data <= is_sample ? shift_in(rx_shift, pin_s2[`PIN_SDI], cfg.msb_first) : rx_shift;
                state <= S_IDLE;
              end
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Next word only taken when the receive buffer has room, so no word is lost
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tx_ready_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      tx_ready_o <= port_on && (state == S_IDLE) && !tx_take && buf_ready && !push_valid && (cap_pipe == 2'b00);
      busy_o <= (state != S_IDLE) || tx_take;
    end
  end

  two_entry_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_rx_buffer (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push_valid),
    .in_data_i(push_data),
    .in_ready_o(buf_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_data_o),
    .out_ready_i(rx_ready_i)
  );

  // ***************************************************************
  // Status flags
  // ***************************************************************
  logic frame_abort;

  assign frame_abort = port_on && is_slave && cfg.sel_en && (state == S_SHIFT) && !selected;

  // A setting event beats a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      transfer_done_flag_o <= 1'b0;
      incomplete_transfer_flag_o <= 1'b0;
    end else begin
      if (push_valid || frame_abort) begin
        transfer_done_flag_o <= 1'b1;
      end else if (transfer_done_clear_i) begin
        transfer_done_flag_o <= 1'b0;
      end
      // Software set raises only the incomplete flag, never done
      if (frame_abort || incomplete_set_i) begin
        incomplete_transfer_flag_o <= 1'b1;
      end else if (incomplete_clear_i) begin
        incomplete_transfer_flag_o <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Pin direction and pull-ups
  // ***************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sdo_oe_o <= 1'b0;
      sck_oe_o <= 1'b0;
      slave_select_n_o <= 1'b1;
      slave_select_n_oe_o <= 1'b0;
      pullup_en_o <= 3'h0;
      two_wire_mode_o <= 1'b0;
    end else begin
      sdo_oe_o <= port_on && (is_master || selected);
      sck_oe_o <= port_on && is_master;
      // Single select pin driven low only around a master frame
      slave_select_n_o <= !(is_master && state == S_SHIFT);
      slave_select_n_oe_o <= port_on && is_master && cfg.sel_en;
      pullup_en_o[`PIN_SDI] <= port_on && pullup_select_i[`PIN_SDI];
      pullup_en_o[`PIN_SCK] <= port_on && is_slave && pullup_select_i[`PIN_SCK];
      pullup_en_o[`PIN_SEL] <= port_on && is_slave && cfg.sel_en && pullup_select_i[`PIN_SEL];
      two_wire_mode_o <= cfg.enable && pin_function_select_i && (cfg.mode == `MODE_TWO_WIRE);
    end
  end

endmodule

`default_nettype wire

// ### tb/spi_port_monitor.sv
// Concurrent checks on the serial port pins, flags and handshake
`timescale 1ns/100ps
`default_nettype none
module spi_port_monitor (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] module_mode_field_i,
  input wire logic module_enable_i,
  input wire logic pin_function_select_i,
  input wire logic [2:0] pullup_select_i,
  input wire logic clock_idle_polarity_i,
  input wire logic select_pin_enable_i,
  input wire logic incomplete_set_i,
  input wire logic tx_ready_o,
  input wire logic transfer_done_flag_o,
  input wire logic incomplete_transfer_flag_o,
  input wire logic busy_o,
  input wire logic two_wire_mode_o,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic slave_select_n_o,
  input wire logic slave_select_n_oe_o,
  input wire logic [2:0] pullup_en_o
);
  // ********
  // Clock toggles per frame
  // ********
  logic [4:0] edges;
  logic sck_q;
  logic busy_q;
  always_ff @(posedge sys_clk_i) begin
    sck_q <= sck_o;
    busy_q <= busy_o;
  end
  // A toggle in the frame's first cycle still counts
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) edges <= 5'h00;
    else if (busy_o && !busy_q) edges <= {4'h0, sck_o != sck_q};
    else if (sck_o != sck_q) edges <= edges + 5'h01;
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_OFF_QUIET: assert property (!(module_enable_i && pin_function_select_i) |=> !sck_oe_o && !slave_select_n_oe_o)
    else $error("port off or unassigned but a pin is driven");
  AST_OFF_IDLE: assert property (!module_enable_i |=> sck_o == !$past(clock_idle_polarity_i))
    else $error("disabled clock not at idle level");
  AST_SEL_RELEASED: assert property (!select_pin_enable_i |=> !slave_select_n_oe_o)
    else $error("select pin driven while released");
  AST_SLAVE_FOLLOWS: assert property (module_mode_field_i == 3'h5 |=> !sck_oe_o && !slave_select_n_oe_o)
    else $error("slave drives clock or select");
  AST_SEL_IN_FRAME: assert property (slave_select_n_oe_o && !slave_select_n_o |-> busy_o || $past(busy_o))
    else $error("select low outside a frame");
  AST_INCOMPLETE_DONE: assert property ($rose(incomplete_transfer_flag_o) && !$past(incomplete_set_i)
    |-> transfer_done_flag_o)
    else $error("incomplete flag without done flag");
  AST_FRAME_EDGES: assert property ($fell(busy_o) && module_mode_field_i < 3'h5 |-> ##2 edges == 5'h10)
    else $error("master frame not sixteen clock edges");
  AST_NO_TAKE_BUSY: assert property (busy_o |-> !tx_ready_o)
    else $error("ready during a frame");
  AST_PULLUPS: assert property (1'b1 |=> (pullup_en_o & ~($past(pullup_select_i)
    & {3{$past(module_enable_i && pin_function_select_i)}})) == 3'h0)
    else $error("pull-up on without request or enable");
  AST_TWO_WIRE: assert property (module_enable_i && pin_function_select_i && module_mode_field_i == 3'h6
    |=> two_wire_mode_o)
    else $error("two-wire mode not reported");
endmodule
`default_nettype wire

// ### tb/spi_peer_model.sv
// Behavioural slave peripheral on the far side of the link
`timescale 1ns/100ps
`default_nettype none
module spi_peer_model (
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  input wire logic rise_i,
  input wire logic msb_i,
  input wire logic [7:0] word_i,
  output logic miso_o,
  output logic [7:0] got_o
);
  logic [7:0] sh;
  int n;
  initial begin
    miso_o = 1'b0;
    got_o = 8'h00;
    sh = 8'h00;
    n = 0;
  end
  always @(negedge sel_n_i) begin
    sh = word_i;
    n = 0;
    miso_o = msb_i ? sh[7] : sh[0];
  end
  // Released line shows the inverse, not a stale level
  always @(posedge sel_n_i) miso_o = ~miso_o;
  always @(sck_i) begin
    if (!sel_n_i) begin
      if (sck_i == rise_i) begin
        got_o = msb_i ? {got_o[6:0], mosi_i} : {mosi_i, got_o[7:1]};
        n++;
      end else if (n > 0) begin
        sh = msb_i ? sh << 1 : sh >> 1;
        miso_o = msb_i ? sh[7] : sh[0];
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the serial port in master and slave use
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; $display("ERROR %s expected %h seen %h", n, e, a); end end
module tb import spi_port_pkg::*; ;
  logic clk, rst, pin_fn, sub, tmr, txv, rxr, dclr, iclr, iset, ssck, ssel, ssdi;
  logic txr, rxv, done, inc, busy, tw, sdo, sck_o, sck_oe, sel_o, sel_oe, miso;
  logic [2:0] pu;
  logic [7:0] txd, pw, got, rxd, e;
  logic [7:0] exp_q[$];
  spi_cfg_t c;
  int failures, compares, i;
  wire logic sck_w = sck_oe ? sck_o : ssck;
  wire logic sel_w = sel_oe ? sel_o : ssel;
  wire logic sdi_w = (c.mode == 3'h5) ? ssdi : miso;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    sub = 1'b0;
    forever #36 sub = ~sub;
  end
  always @(posedge clk) tmr <= ($urandom_range(3) == 0);
  spi_port i_dut (.sys_clk_i(clk), .sys_rst_i(rst), .module_mode_field_i(c.mode),
    .module_enable_i(c.enable), .pin_function_select_i(pin_fn), .pullup_select_i(pu),
    .clock_idle_polarity_i(c.idle_low), .clock_edge_select_i(c.edge_sel), .bit_order_select_i(c.msb_first),
    .select_pin_enable_i(c.sel_en), .sub_clock_i(sub), .timer_match_i(tmr), .tx_valid_i(txv),
    .tx_data_i(txd), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rxr),
    .transfer_done_flag_o(done), .transfer_done_clear_i(dclr), .incomplete_transfer_flag_o(inc),
    .incomplete_clear_i(iclr), .incomplete_set_i(iset), .busy_o(busy), .two_wire_mode_o(tw),
    .sdi_i(sdi_w), .sdo_o(sdo), .sdo_oe_o(), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe),
    .slave_select_n_i(sel_w), .slave_select_n_o(sel_o), .slave_select_n_oe_o(sel_oe), .pullup_en_o());
  spi_peer_model i_peer (.sck_i(sck_w), .sel_n_i(sel_w), .mosi_i(sdo), .rise_i(c.idle_low == c.edge_sel),
    .msb_i(c.msb_first), .word_i(pw), .miso_o(miso), .got_o(got));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic hit(int w);
    return w == 0 ? done === 1'b1 : w == 1 ? rxv === 1'b1 : txr === 1'b1;
  endfunction
  task automatic wait_for(int w, int n);
    int k;
    for (k = 0; k < n && !hit(w); k++) @(posedge clk);
    if (k == n) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic send(logic [7:0] d);
    wait_for(2, 600);
    txv <= 1'b1;
    txd <= d;
    @(posedge clk);
    txv <= 1'b0;
  endtask
  task automatic pop();
    wait_for(1, 50);
    e = exp_q.pop_front();
    `CHK("rx_data", e, rxd)
    rxr <= 1'b1;
    @(posedge clk);
    rxr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic clear_flags();
    dclr <= 1'b1;
    iclr <= 1'b1;
    @(posedge clk);
    dclr <= 1'b0;
    iclr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic master(int m);
    logic [7:0] d;
    d = 8'($urandom);
    @(posedge clk);
    c.mode <= m[2:0];
    {c.idle_low, c.edge_sel, c.msb_first} <= 3'($urandom);
    pu <= 3'($urandom);
    pw <= 8'($urandom);
    repeat (4) @(posedge clk);
    send(d);
    wait_for(0, 4000);
    `CHK("peer_rx", d, got)
    exp_q.push_back(pw);
    clear_flags();
    `CHK("done_clear", 1'b0, done)
    $display("master test mode %0d finished", m);
  endtask
  task automatic slave(int n, logic [7:0] s);
    logic [7:0] d, q;
    int b;
    d = 8'($urandom);
    q = 8'h00;
    @(posedge clk);
    c <= '{3'h5, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    repeat (4) @(posedge clk);
    send(d);
    repeat (2) @(posedge clk);
    ssel <= 1'b0;
    for (b = 7; b > 7 - n; b--) begin
      ssdi <= s[b];
      repeat (4) @(posedge clk);
      ssck <= 1'b1;
      repeat (2) @(posedge clk);
      q[b] = sdo;
      repeat (2) @(posedge clk);
      ssck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    ssel <= 1'b1;
    ssdi <= ~ssdi;
    repeat (8) @(posedge clk);
    `CHK("slave_done", 1'b1, done)
    `CHK("slave_incomplete", n < 8, inc)
    if (n == 8) begin
      `CHK("slave_tx", d, q)
      exp_q.push_back(s);
      pop();
    end else `CHK("no_word", 1'b0, rxv)
    clear_flags();
    $display("slave test with %0d bits finished", n);
  endtask
  initial begin
    c = '{3'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    {pin_fn, rst} = 2'b11;
    {txv, rxr, dclr, iclr, iset, ssck, ssdi} = 7'h00;
    ssel = 1'b1;
    {pu, txd, pw} = 19'h0;
    failures = 0;
    compares = 0;
    void'($urandom(32'h48a9));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Receiver stalls: two words fill the buffer, then it refuses
    for (i = 0; i < 10; i++) begin
      master(i % 5);
      if (i % 2) begin
        `CHK("tx_blocked", 1'b0, txr)
        pop();
        pop();
      end
    end
    slave(8, 8'($urandom));
    slave(3, 8'($urandom));
    iset <= 1'b1;
    @(posedge clk);
    iset <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("soft_incomplete", 1'b1, inc)
    `CHK("soft_no_done", 1'b0, done)
    c <= '{3'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    repeat (4) @(posedge clk);
    `CHK("idle_clock", 1'b0, sck_o)
    `CHK("off_clock_drive", 1'b0, sck_oe)
    c.enable <= 1'b1;
    pin_fn <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("unassigned_drive", 1'b0, sck_oe)
    pin_fn <= 1'b1;
    c.mode <= 3'h6;
    repeat (4) @(posedge clk);
    `CHK("two_wire", 1'b1, tw)
    c.mode <= 3'h7;
    repeat (4) @(posedge clk);
    `CHK("mode_off", 2'b00, {tw, sck_oe})
    $display("mode and disable test finished");
    complete_run();
  end
endmodule
bind spi_port spi_port_monitor i_mon (.*);
`default_nettype wire
